// file: bench/ppdc_board.sv
/*
 board model for the pads: strong port drive, then external source,
 then pulls; a floating pin toggles so a stale level never passes.
 assumes registered pad controls from ppdc_port.
*/
`timescale 1ns/1ns
`default_nettype none
module ppdc_board (
	// clock
	input wire logic       clock,
	// pad controls
	input wire logic [7:0] pad_out_ff, pad_oe_ff, pad_pu_ff, pad_pd_ff,
	// external strong source
	input wire logic [7:0] ext_en, ext_val,
	// level seen by the port
	output var logic [7:0] pad_in = 8'h00
);
	// registered so pad_in stays synchronous to clock
	always @(posedge clock) begin
		pad_in <= (pad_oe_ff & pad_out_ff) | (~pad_oe_ff & ext_en & ext_val)
			| (~pad_oe_ff & ~ext_en & (pad_pu_ff | (~pad_pd_ff & ~pad_in)));
	end
endmodule // ppdc_board
`default_nettype wire

// file: bench/ppdc_sva.sv
/*
 checker for the port pin drive control block.
 assumes it is bound to ppdc_port, one clock, srst synchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module ppdc_sva (
	// clock and reset
	input wire logic       clock, srst,
	// port form access
	input wire logic       pw_we,
	input wire logic [3:0] pw_sel, pw_rd_sel,
	input wire logic [7:0] pw_rdata_ff,
	// pads and fabric
	input wire logic [7:0] pad_in, periph_in_ff, pad_oe_ff, pad_pu_ff, pad_pd_ff,
	input wire logic [7:0] pad_slow_ff, pad_ibuf_en_ff,
	input wire logic       port_irq_ff
);
	// pad copy one edge late lines up with the enable that gated it, so ps mirrors pin state
	logic [7:0] pad_in_d = 8'h00;
	wire  [7:0] ps = pad_in_d & pad_ibuf_en_ff;
	always @(posedge clock) pad_in_d <= pad_in;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	property p_rst;
		disable iff (1'b0) srst |=> (pad_oe_ff | pad_pu_ff | pad_pd_ff | pad_ibuf_en_ff) == 8'h00
			&& !port_irq_ff;
	endproperty
	property p_excl;
		((pad_pu_ff & pad_pd_ff) | (pad_oe_ff & (pad_pu_ff | pad_pd_ff))) == 8'h00;
	endproperty
	property p_slow;
		(pad_slow_ff & (pad_pu_ff | pad_pd_ff)) == 8'h00;
	endproperty
	property p_ps;
		!$past(srst) |-> periph_in_ff == $past(ps);
	endproperty
	property p_rdps;
		!$past(srst) && $past(pw_rd_sel) == 4'hc |-> pw_rdata_ff == $past(ps);
	endproperty
	property p_rdnone;
		!$past(srst) && $past(pw_rd_sel) > 4'hc |-> pw_rdata_ff == 8'h00;
	endproperty
	property p_irq_set;
		$rose(port_irq_ff) |-> $past(ps) != $past(ps, 2);
	endproperty
	property p_irq_hold;
		port_irq_ff && !(pw_we && pw_sel == 4'hb) |=> port_irq_ff;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	a_excl: assert property (p_excl) else $error("drive and pull overlap");
	a_slow: assert property (p_slow) else $error("slow edge in resistive drive");
	a_ps: assert property (p_ps) else $error("fabric input wrong");
	a_rdps: assert property (p_rdps) else $error("pin state read wrong");
	a_rdnone: assert property (p_rdnone) else $error("unmapped read not zero");
	a_irq_set: assert property (p_irq_set) else $error("request without edge");
	a_irq_hold: assert property (p_irq_hold) else $error("request dropped");
	c_irq: cover property ($rose(port_irq_ff));
	c_pu: cover property (pad_pu_ff != 8'h00);
	c_oe: cover property (pad_oe_ff == 8'hff);
endmodule // ppdc_sva
`default_nettype wire

// file: bench/tb.sv
/*
 self-checking bench for ppdc_port with a board model.
 assumes ppdc_sva and ppdc_board compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        clock = 0, srst = 1, pw_we = 0, pf_we = 0, oer_we = 0;
	logic [1:0]  rst_cfg_mode = 2'h0;
	logic [3:0]  pw_sel = 4'h0, pw_rd_sel = 4'h0, oer_wdata = 4'h0;
	logic [2:0]  pf_idx = 3'h0, pf_rd_idx = 3'h0, oer_idx = 3'h0;
	logic [7:0]  pw_wdata = 8'h00, pf_wdata = 8'h00, periph_out = 8'h00, ext_en = 8'h00;
	logic [7:0]  ext_val = 8'h00, dv, sv;
	logic [15:0] aux_oe = 16'h0000, rnd = 16'h3191;
	wire  [7:0]  pad_in, pw_rdata_ff, pf_rdata_ff, periph_in_ff, pad_out_ff, pad_oe_ff;
	wire  [7:0]  pad_pu_ff, pad_pd_ff, pad_slow_ff, pad_ibuf_en_ff;
	wire         port_irq_ff;
	int          errors = 0, compares = 0, i, p;
	logic [2:0]  m[8];
	logic [7:0]  e[6];
	ppdc_port i_ppdc_port (
		.clock(clock), .srst(srst), .rst_cfg_mode(rst_cfg_mode),
		.pw_we(pw_we), .pw_sel(pw_sel), .pw_wdata(pw_wdata),
		.pw_rd_sel(pw_rd_sel), .pw_rdata_ff(pw_rdata_ff),
		.pf_we(pf_we), .pf_idx(pf_idx), .pf_wdata(pf_wdata),
		.pf_rd_idx(pf_rd_idx), .pf_rdata_ff(pf_rdata_ff),
		.oer_we(oer_we), .oer_idx(oer_idx), .oer_wdata(oer_wdata),
		.periph_out(periph_out), .aux_oe(aux_oe), .periph_in_ff(periph_in_ff),
		.pad_in(pad_in), .pad_out_ff(pad_out_ff), .pad_oe_ff(pad_oe_ff),
		.pad_pu_ff(pad_pu_ff), .pad_pd_ff(pad_pd_ff), .pad_slow_ff(pad_slow_ff),
		.pad_ibuf_en_ff(pad_ibuf_en_ff), .port_irq_ff(port_irq_ff)
	);
	ppdc_board i_ppdc_board (
		.clock(clock), .pad_out_ff(pad_out_ff), .pad_oe_ff(pad_oe_ff),
		.pad_pu_ff(pad_pu_ff), .pad_pd_ff(pad_pd_ff),
		.ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in)
	);
	initial forever #5 clock = ~clock;
	function automatic [15:0] lf(input [15:0] s);
		lf = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// {oe, pu, pd, slow, ibuf} of one pin
	function automatic [4:0] ex(input [2:0] c, input d, input s);
		ex = {c == 3'h6 || (c == 3'h2 || c == 3'h4) && !d || (c == 3'h3 || c == 3'h5) && d,
			(c == 3'h2 || c == 3'h7) && d, (c == 3'h3 || c == 3'h7) && !d,
			s && c >= 3'h4 && c <= 3'h6, c != 3'h0};
	endfunction
	task automatic chk(input string n, input [7:0] s, input [7:0] x);
		compares++;
		if (s !== x) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, s);
		end
	endtask
	// k picks the strobe: 0 port form, 1 pin form, 2 oe routing
	task automatic wr(input [1:0] k, input [3:0] a, input [7:0] d);
		@(posedge clock);
		pw_we <= k == 2'h0; pf_we <= k == 2'h1; oer_we <= k == 2'h2;
		pw_sel <= a; pf_idx <= a[2:0]; oer_idx <= a[2:0];
		pw_wdata <= d; pf_wdata <= d; oer_wdata <= d[3:0];
		@(posedge clock);
		pw_we <= 0; pf_we <= 0; oer_we <= 0;
	endtask
	task automatic st;
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic rd(input [3:0] s);
		@(posedge clock);
		pw_rd_sel <= s;
		pf_rd_idx <= s[2:0];
		st;
	endtask
	task automatic rst(input [1:0] c);
		@(posedge clock);
		srst <= 1; rst_cfg_mode <= c;
		repeat (12) @(posedge clock);
		srst <= 0;
		repeat (3) @(posedge clock);
		#1;
	endtask
	task automatic conclude;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		conclude;
	end
	initial begin
		for (i = 0; i < 4; i++) begin
			rst(i[1:0]);
			chk("rst_pu", pad_pu_ff, i == 1 ? 8'hff : 8'h00);
			chk("rst_pd", pad_pd_ff, i == 2 ? 8'hff : 8'h00);
		end
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			for (p = 0; p < 8; p++) begin
				rnd = lf(rnd); m[p] = 3'(i + p); dv[p] = rnd[0]; sv[p] = rnd[1];
				wr(2'h1, p[3:0], {sv[p], 2'h0, m[p], rnd[2], dv[p]});
			end
			st;
			for (p = 0; p < 8; p++) begin
				{e[0][p], e[1][p], e[2][p], e[3][p], e[4][p]} = ex(m[p], dv[p], sv[p]);
				e[5][p] = m[p][0];
			end
			chk("oe", pad_oe_ff, e[0]);
			chk("pu", pad_pu_ff, e[1]);
			chk("pd", pad_pd_ff, e[2]);
			chk("slow", pad_slow_ff, e[3]);
			chk("ibuf", pad_ibuf_en_ff, e[4]);
			chk("out", pad_out_ff & (e[0] | e[1] | e[2]), dv & (e[0] | e[1] | e[2]));
			rd(4'h1);
			chk("dm0", pw_rdata_ff, e[5]);
			chk("pin", pf_rdata_ff & 8'hfd, {sv[1], 2'h0, m[1], 1'b0, dv[1]});
		end
		$display("test modes done");
		wr(2'h0, 4'h1, 8'h00); wr(2'h0, 4'h2, 8'hff); wr(2'h0, 4'h3, 8'hff);
		@(posedge clock) periph_out <= rnd[15:8];
		wr(2'h0, 4'h4, 8'hff); st;
		chk("byp", pad_out_ff, rnd[15:8]);
		chk("strong", pad_oe_ff, 8'hff);
		for (p = 0; p < 8; p++) wr(2'h2, p[3:0], 8'(2 * p));
		wr(2'h0, 4'h5, 8'hff);
		@(posedge clock) aux_oe <= rnd;
		st;
		for (p = 0; p < 8; p++) e[0][p] = rnd[2 * p];
		chk("bidir", pad_oe_ff, e[0]);
		wr(2'h0, 4'h5, 8'h00); wr(2'h0, 4'h4, 8'h00); wr(2'h0, 4'h1, 8'hff);
		wr(2'h0, 4'h0, 8'h0f); wr(2'h0, 4'ha, 8'hff); st;
		chk("regm", pad_pu_ff | pad_pd_ff, 8'h00);
		wr(2'h0, 4'ha, 8'h00); st;
		chk("pull", {pad_pu_ff[3:0], pad_pd_ff[7:4]}, 8'hff);
		wr(2'h0, 4'h2, 8'h00); wr(2'h0, 4'h3, 8'h00);
		wr(2'h0, 4'h7, 8'h0f); wr(2'h0, 4'h8, 8'hf0);
		@(posedge clock) ext_en <= 8'hff;
		repeat (4) @(posedge clock);
		wr(2'h0, 4'hb, 8'hff);
		@(posedge clock) ext_val <= 8'hff;
		repeat (4) @(posedge clock);
		rd(4'hb);
		chk("irq", {7'h00, port_irq_ff}, 8'h01);
		chk("rise", pw_rdata_ff, 8'h0f);
		wr(2'h0, 4'hb, 8'hff); st;
		chk("clr", {7'h00, port_irq_ff}, 8'h00);
		@(posedge clock) ext_val <= 8'h00;
		repeat (4) @(posedge clock);
		rd(4'hb);
		chk("fall", pw_rdata_ff, 8'hf0);
		wr(2'h0, 4'h9, 8'hff);
		@(posedge clock) ext_val <= 8'hff;
		rd(4'hc);
		chk("indis", pw_rdata_ff, 8'h00);
		rd(4'hd);
		chk("unmapped", pw_rdata_ff, 8'h00);
		$display("test port done");
		conclude;
	end
endmodule // tb
bind ppdc_port ppdc_sva i_ppdc_sva (
	.clock(clock), .srst(srst), .pw_we(pw_we), .pw_sel(pw_sel),
	.pw_rd_sel(pw_rd_sel), .pw_rdata_ff(pw_rdata_ff), .pad_in(pad_in),
	.periph_in_ff(periph_in_ff), .pad_oe_ff(pad_oe_ff), .pad_pu_ff(pad_pu_ff),
	.pad_pd_ff(pad_pd_ff), .pad_slow_ff(pad_slow_ff),
	.pad_ibuf_en_ff(pad_ibuf_en_ff), .port_irq_ff(port_irq_ff)
);
`default_nettype wire

// file: rtl/ppdc_map.vh
/*
 constants for the port pin drive control block.
 assumes a single 8-pin port on one synchronous clock.
*/
// Function
// - each pin owns a three-bit drive mode
// - code 000: driver and input buffer off
// - code 001: driver off, input readable
// - 010 resistive high/strong low; 011 inverse
// - 100 open drain low; 101 open drain high
// - 110 strong both states, follows data
// - 111 resistive pull-up or pull-down only
// - regulated special pins lose resistive drive
// - drive data from register or bypass signal
// - separate read-only pin state, output register
// - port form bit n maps pin n
// - per-pin register shares the same storage
// - bidirectional: oe picks input or mode
// - sixteen routable output enables per pin
// - slew select only on strong, open drain
// - per pin rising, falling or both edges
// - one interrupt line for the port
// - user programmable port reset state
// - edge event sets status bit, raises request
// - reset holds analog; load config at release
`ifndef PPDC_MAP_VH
`define PPDC_MAP_VH

`define PPDC_DM_HIZA 3'h0
`define PPDC_DM_HIZD 3'h1
`define PPDC_DM_RPU  3'h2
`define PPDC_DM_RPD  3'h3
`define PPDC_DM_ODL  3'h4
`define PPDC_DM_ODH  3'h5
`define PPDC_DM_STR  3'h6
`define PPDC_DM_RPUD 3'h7

`define PPDC_SEL_DR    4'h0
`define PPDC_SEL_DM0   4'h1
`define PPDC_SEL_DM1   4'h2
`define PPDC_SEL_DM2   4'h3
`define PPDC_SEL_BYP   4'h4
`define PPDC_SEL_BIE   4'h5
`define PPDC_SEL_SLW   4'h6
`define PPDC_SEL_RISE  4'h7
`define PPDC_SEL_FALL  4'h8
`define PPDC_SEL_INDIS 4'h9
`define PPDC_SEL_REGM  4'ha
`define PPDC_SEL_STAT  4'hb
`define PPDC_SEL_PS    4'hc

`define PPDC_PF_DR   0
`define PPDC_PF_PS   1
`define PPDC_PF_DM0  2
`define PPDC_PF_DM2  4
`define PPDC_PF_BYP  5
`define PPDC_PF_BIE  6
`define PPDC_PF_SLW  7

`define PPDC_RST_HIZ 2'h0
`define PPDC_RST_PU  2'h1
`define PPDC_RST_PD  2'h2

`define PPDC_ZERO8 8'h00
`define PPDC_ONES8 8'hff
`define PPDC_ZERO32 32'h0000_0000
`define PPDC_OESEL_W 4

`endif

// file: rtl/ppdc_port.v
/*
 port pin drive control: one 8-pin port with drive modes, data
 registers in port and pin form, bidirectional control, slew select
 and edge interrupts.
 assumes pad inputs already synchronous to clock and external pad
 cells that honour the oe, pull-up and pull-down controls.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ppdc_map.vh"

module ppdc_port (
	// clock and reset
	input  wire        clock,
	input  wire        srst,
	// stored reset configuration
	input  wire [1:0]  rst_cfg_mode,
	// port form access
	input  wire        pw_we,
	input  wire [3:0]  pw_sel,
	input  wire [7:0]  pw_wdata,
	input  wire [3:0]  pw_rd_sel,
	output reg  [7:0]  pw_rdata_ff,
	// pin form access
	input  wire        pf_we,
	input  wire [2:0]  pf_idx,
	input  wire [7:0]  pf_wdata,
	input  wire [2:0]  pf_rd_idx,
	output reg  [7:0]  pf_rdata_ff,
	// output enable routing
	input  wire        oer_we,
	input  wire [2:0]  oer_idx,
	input  wire [3:0]  oer_wdata,
	// routing fabric
	input  wire [7:0]  periph_out,
	input  wire [15:0] aux_oe,
	output reg  [7:0]  periph_in_ff,
	// pads
	input  wire [7:0]  pad_in,
	output reg  [7:0]  pad_out_ff,
	output reg  [7:0]  pad_oe_ff,
	output reg  [7:0]  pad_pu_ff,
	output reg  [7:0]  pad_pd_ff,
	output reg  [7:0]  pad_slow_ff,
	output reg  [7:0]  pad_ibuf_en_ff,
	// interrupt
	output reg         port_irq_ff
);

	// per-pin drive decode: {oe, out, pull_up, pull_down}
	function [3:0] ppdc_drive;
		input [2:0] dm;
		input       d;
		input       rg;
		reg         oe;
		reg         pu;
		reg         pd;
		begin
			oe = 1'b0;
			pu = 1'b0;
			pd = 1'b0;
			case (dm)
				`PPDC_DM_HIZA: oe = 1'b0;
				`PPDC_DM_HIZD: oe = 1'b0;
				`PPDC_DM_RPU: begin
					oe = ~d;
					pu = d & ~rg;
				end
				`PPDC_DM_RPD: begin
					oe = d;
					pd = ~d & ~rg;
				end
				`PPDC_DM_ODL: oe = ~d;
				`PPDC_DM_ODH: oe = d;
				`PPDC_DM_STR: oe = 1'b1;
				`PPDC_DM_RPUD: begin
					pu = d & ~rg;
					pd = ~d & ~rg;
				end
				default: oe = 1'b0;
			endcase
			ppdc_drive = {oe, d, pu, pd};
		end
	endfunction

	// slew only matters where the driver is strong or open drain
	function ppdc_slewable;
		input [2:0] dm;
		begin
			ppdc_slewable = (dm == `PPDC_DM_ODL) || (dm == `PPDC_DM_ODH) ||
				(dm == `PPDC_DM_STR);
		end
	endfunction

	// configuration storage, port form bit n is pin n
	reg  [7:0]  dr_ff;
	reg  [7:0]  dm0_ff;
	reg  [7:0]  dm1_ff;
	reg  [7:0]  dm2_ff;
	reg  [7:0]  byp_ff;
	reg  [7:0]  bie_ff;
	reg  [7:0]  slw_ff;
	reg  [7:0]  rise_ff;
	reg  [7:0]  fall_ff;
	reg  [7:0]  indis_ff;
	reg  [7:0]  regm_ff;
	reg  [31:0] oesel_ff;
	reg         rst_d_ff;

	// pin state and interrupt state
	reg  [7:0]  ps_ff;
	reg  [7:0]  ps_prev_ff;
	reg  [7:0]  stat_ff;

	// combinational per-pin results
	reg  [7:0]  nxt_out;
	reg  [7:0]  nxt_oe;
	reg  [7:0]  nxt_pu;
	reg  [7:0]  nxt_pd;
	reg  [7:0]  nxt_slow;
	reg  [7:0]  nxt_ibuf;
	reg  [7:0]  nxt_stat;
	reg  [7:0]  nxt_pw_rdata;
	reg  [7:0]  nxt_pf_rdata;
	reg  [7:0]  edge_hit;
	reg  [2:0]  eff_dm;
	reg  [3:0]  drv;
	reg         d_val;
	integer     i;

	// one-cycle marker of reset release, used to load the reset state
	always @(posedge clock) begin
		rst_d_ff <= srst;
	end

	// configuration writes; pin form wins over port form in one cycle
	always @(posedge clock) begin
		if (srst) begin
			dr_ff    <= `PPDC_ZERO8;
			dm0_ff   <= `PPDC_ZERO8;
			dm1_ff   <= `PPDC_ZERO8;
			dm2_ff   <= `PPDC_ZERO8;
			byp_ff   <= `PPDC_ZERO8;
			bie_ff   <= `PPDC_ZERO8;
			slw_ff   <= `PPDC_ZERO8;
			rise_ff  <= `PPDC_ZERO8;
			fall_ff  <= `PPDC_ZERO8;
			indis_ff <= `PPDC_ZERO8;
			regm_ff  <= `PPDC_ZERO8;
			oesel_ff <= `PPDC_ZERO32;
		end else begin
			if (rst_d_ff) begin
				// pull-up is mode 010 with data 1, pull-down is 011 with data 0
				if (rst_cfg_mode == `PPDC_RST_PU) begin
					dm1_ff <= `PPDC_ONES8;
					dr_ff  <= `PPDC_ONES8;
				end else if (rst_cfg_mode == `PPDC_RST_PD) begin
					dm1_ff <= `PPDC_ONES8;
					dm0_ff <= `PPDC_ONES8;
				end
			end
			if (pw_we) begin
				case (pw_sel)
					`PPDC_SEL_DR:    dr_ff    <= pw_wdata;
					`PPDC_SEL_DM0:   dm0_ff   <= pw_wdata;
					`PPDC_SEL_DM1:   dm1_ff   <= pw_wdata;
					`PPDC_SEL_DM2:   dm2_ff   <= pw_wdata;
					`PPDC_SEL_BYP:   byp_ff   <= pw_wdata;
					`PPDC_SEL_BIE:   bie_ff   <= pw_wdata;
					`PPDC_SEL_SLW:   slw_ff   <= pw_wdata;
					`PPDC_SEL_RISE:  rise_ff  <= pw_wdata;
					`PPDC_SEL_FALL:  fall_ff  <= pw_wdata;
					`PPDC_SEL_INDIS: indis_ff <= pw_wdata;
					`PPDC_SEL_REGM:  regm_ff  <= pw_wdata;
					default:         dr_ff    <= dr_ff;
				endcase
			end
			if (pf_we) begin
				dr_ff[pf_idx]  <= pf_wdata[`PPDC_PF_DR];
				dm0_ff[pf_idx] <= pf_wdata[`PPDC_PF_DM0];
				dm1_ff[pf_idx] <= pf_wdata[`PPDC_PF_DM0 + 1];
				dm2_ff[pf_idx] <= pf_wdata[`PPDC_PF_DM2];
				byp_ff[pf_idx] <= pf_wdata[`PPDC_PF_BYP];
				bie_ff[pf_idx] <= pf_wdata[`PPDC_PF_BIE];
				slw_ff[pf_idx] <= pf_wdata[`PPDC_PF_SLW];
			end
			if (oer_we) begin
				oesel_ff[oer_idx * `PPDC_OESEL_W +: `PPDC_OESEL_W] <= oer_wdata;
			end
		end
	end

	// per-pin drive, input buffer and edge decode
	always @* begin
		nxt_out  = `PPDC_ZERO8;
		nxt_oe   = `PPDC_ZERO8;
		nxt_pu   = `PPDC_ZERO8;
		nxt_pd   = `PPDC_ZERO8;
		nxt_slow = `PPDC_ZERO8;
		nxt_ibuf = `PPDC_ZERO8;
		edge_hit = `PPDC_ZERO8;
		eff_dm   = `PPDC_DM_HIZA;
		drv      = 4'h0;
		d_val    = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			eff_dm = {dm2_ff[i], dm1_ff[i], dm0_ff[i]};
			// with oe low a bidirectional pin falls back to a plain input
			if (bie_ff[i] && !aux_oe[oesel_ff[i * `PPDC_OESEL_W +: `PPDC_OESEL_W]])
				eff_dm = `PPDC_DM_HIZD;
			d_val = byp_ff[i] ? periph_out[i] : dr_ff[i];
			drv = ppdc_drive(eff_dm, d_val, regm_ff[i]);
			nxt_oe[i]   = drv[3];
			nxt_out[i]  = drv[2];
			nxt_pu[i]   = drv[1];
			nxt_pd[i]   = drv[0];
			nxt_slow[i] = slw_ff[i] & ppdc_slewable(eff_dm);
			// strong mode keeps the buffer on; reading it just echoes the drive
			nxt_ibuf[i] = ({dm2_ff[i], dm1_ff[i], dm0_ff[i]} != `PPDC_DM_HIZA) &
				~indis_ff[i];
			edge_hit[i] = (rise_ff[i] & ps_ff[i] & ~ps_prev_ff[i]) |
				(fall_ff[i] & ~ps_ff[i] & ps_prev_ff[i]);
		end
	end

	// status: a new edge in the clearing cycle survives the clear
	always @* begin
		nxt_stat = stat_ff;
		if (pw_we && (pw_sel == `PPDC_SEL_STAT))
			nxt_stat = stat_ff & ~pw_wdata;
		nxt_stat = nxt_stat | edge_hit;
	end

	// read paths
	always @* begin
		case (pw_rd_sel)
			`PPDC_SEL_DR:    nxt_pw_rdata = dr_ff;
			`PPDC_SEL_DM0:   nxt_pw_rdata = dm0_ff;
			`PPDC_SEL_DM1:   nxt_pw_rdata = dm1_ff;
			`PPDC_SEL_DM2:   nxt_pw_rdata = dm2_ff;
			`PPDC_SEL_BYP:   nxt_pw_rdata = byp_ff;
			`PPDC_SEL_BIE:   nxt_pw_rdata = bie_ff;
			`PPDC_SEL_SLW:   nxt_pw_rdata = slw_ff;
			`PPDC_SEL_RISE:  nxt_pw_rdata = rise_ff;
			`PPDC_SEL_FALL:  nxt_pw_rdata = fall_ff;
			`PPDC_SEL_INDIS: nxt_pw_rdata = indis_ff;
			`PPDC_SEL_REGM:  nxt_pw_rdata = regm_ff;
			`PPDC_SEL_STAT:  nxt_pw_rdata = stat_ff;
			`PPDC_SEL_PS:    nxt_pw_rdata = ps_ff;
			default:         nxt_pw_rdata = `PPDC_ZERO8;
		endcase
		nxt_pf_rdata = {slw_ff[pf_rd_idx], bie_ff[pf_rd_idx], byp_ff[pf_rd_idx],
			dm2_ff[pf_rd_idx], dm1_ff[pf_rd_idx], dm0_ff[pf_rd_idx],
			ps_ff[pf_rd_idx], dr_ff[pf_rd_idx]};
	end

	// pin state and interrupt registers
	always @(posedge clock) begin
		if (srst) begin
			ps_ff       <= `PPDC_ZERO8;
			ps_prev_ff  <= `PPDC_ZERO8;
			stat_ff     <= `PPDC_ZERO8;
			port_irq_ff <= 1'b0;
		end else begin
			ps_ff       <= pad_in & nxt_ibuf;
			ps_prev_ff  <= ps_ff;
			stat_ff     <= nxt_stat;
			port_irq_ff <= |nxt_stat;
		end
	end

	// registered outputs; reset forces every pin to high impedance analog
	always @(posedge clock) begin
		if (srst) begin
			pad_out_ff     <= `PPDC_ZERO8;
			pad_oe_ff      <= `PPDC_ZERO8;
			pad_pu_ff      <= `PPDC_ZERO8;
			pad_pd_ff      <= `PPDC_ZERO8;
			pad_slow_ff    <= `PPDC_ZERO8;
			pad_ibuf_en_ff <= `PPDC_ZERO8;
			periph_in_ff   <= `PPDC_ZERO8;
			pw_rdata_ff    <= `PPDC_ZERO8;
			pf_rdata_ff    <= `PPDC_ZERO8;
		end else begin
			pad_out_ff     <= nxt_out;
			pad_oe_ff      <= nxt_oe;
			pad_pu_ff      <= nxt_pu;
			pad_pd_ff      <= nxt_pd;
			pad_slow_ff    <= nxt_slow;
			pad_ibuf_en_ff <= nxt_ibuf;
			periph_in_ff   <= ps_ff;
			pw_rdata_ff    <= nxt_pw_rdata;
			pf_rdata_ff    <= nxt_pf_rdata;
		end
	end

endmodule // ppdc_port

`default_nettype wire
